//--- inc/trui_defines.svh
// Notes on behaviour
// RULE1: offset field holds fault minus original address
// RULE2: basic load/store immediates written as zero
// RULE3: compressed: expand, transform, then clear bit1
// RULE4: implicit guest-stage fault writes pseudoinstruction, never zero; code writes zero when guest_addr_nonzero is clear
// RULE5: read pseudo 0x2000 width32, 0x3000 width64
// RULE6: write pseudo only for accessed/dirty update
// RULE7: trap instruction register not hardwired zero
// RULE8: machine return: derive mode, clear, pop enable
// RULE9: machine return: switch modes, pc from mepc
// RULE10: supervisor return, virt off: hyp fields, sepc
// RULE11: supervisor return, virt on: guest status, vsepc
// RULE12: user trap: enable to previous, clear enable
// RULE13: user enable clear blocks user interrupts
// RULE14: user enable bits shared in status views
// RULE15: user return: pop enable, pc from uepc
// RULE16: soft pending writable, masked by soft enable
// RULE17: other user pending bits read-only
// RULE18: timer pending, masked by timer enable
// RULE19: external pending, masked by external enable
// RULE20: user pending/enable alias machine/supervisor fields
// RULE21: machine delegation routes user traps, M/U only
// RULE22: supervisor-to-user delegation writable only if delegated
// RULE23: take only pending, enabled, global enable, delegated
`ifndef TRUI_DEFINES_SVH
`define TRUI_DEFINES_SVH
`define TRUI_A_USTATUS 12'h000
`define TRUI_A_UIE 12'h004
`define TRUI_A_UIP 12'h044
`define TRUI_A_UEPC 12'h041
`define TRUI_A_MSTATUS 12'h300
`define TRUI_A_MEDELEG 12'h302
`define TRUI_A_MIDELEG 12'h303
`define TRUI_A_MIE 12'h304
`define TRUI_A_MEPC 12'h341
`define TRUI_A_MIP 12'h344
`define TRUI_A_SEDELEG 12'h102
`define TRUI_A_SIDELEG 12'h103
`define TRUI_A_SIE 12'h104
`define TRUI_A_SEPC 12'h141
`define TRUI_A_SIP 12'h144
`define TRUI_A_MTINST 12'h34a
`define TRUI_A_MODE 12'h7c0
`define TRUI_B_UIE 0
`define TRUI_B_USER_PREV_INT_ENABLE 4
`define TRUI_B_SIE 1
`define TRUI_B_SUPERVISOR_PREV_INT_ENABLE 5
`define TRUI_B_MIE 3
`define TRUI_B_MACHINE_PREV_INT_ENABLE 7
`define TRUI_B_SPP 8
`define TRUI_B_MPP 11
`define TRUI_B_MPV 39
`define TRUI_B_USOFT 0
`define TRUI_B_UTIMER 4
`define TRUI_B_UEXT 8
`define TRUI_PSEUDO_RD32 32'h00002000
`define TRUI_PSEUDO_WR32 32'h00002020
`define TRUI_PSEUDO_RD64 32'h00003000
`define TRUI_PSEUDO_WR64 32'h00003020
`define TRUI_RST_STATUS 64'h0
`endif

//--- inc/trui_pkg.sv
package trui_pkg;
   typedef enum logic [1:0] {TRUI_PRV_U = 2'h0, TRUI_PRV_S = 2'h1, TRUI_PRV_M = 2'h3} trui_priv_t;
   typedef enum logic [2:0] {TRUI_FK_NONE, TRUI_FK_LOAD, TRUI_FK_STORE, TRUI_FK_ATOMIC, TRUI_FK_HYPLS,
      TRUI_FK_GUEST_IMPLICIT} trui_fault_kind_t;
   typedef struct packed {
      logic [11:0] addr;
      logic [63:0] wdata;
      logic wr;
      logic rd;
   } trui_csr_req_t;
   typedef struct packed {
      logic valid;
      trui_fault_kind_t kind;
      logic [31:0] insn;
      logic [4:0] addr_offset;
      logic guest_addr_nonzero;
      logic ad_update;
      logic guest_width64;
   } trui_fault_t;
   typedef struct packed {
      logic machine_trap_return;
      logic supervisor_trap_return;
      logic user_trap_return;
      logic user_trap_take;
   } trui_ctl_t;
   typedef struct packed {
      logic [63:0] status;
      logic [63:0] hstatus_spv;
      logic [63:0] vsstatus;
      logic [63:0] ip;
      logic [63:0] ie;
      logic [63:0] medeleg;
      logic [63:0] mideleg;
      logic [63:0] sedeleg;
      logic [63:0] sideleg;
      logic [63:0] mepc;
      logic [63:0] sepc;
      logic [63:0] vsepc;
      logic [63:0] uepc;
      logic [63:0] pc;
      logic [31:0] tinst;
      logic [1:0] priv;
      logic virt;
      logic [63:0] rdata;
      logic uirq;
      logic [1:0] smode_sync;
   } trui_state_t;
endpackage : trui_pkg

//--- hdl/trui_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "trui_defines.svh"
module trui_unit (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // configuration strap
   input wire logic HAS_SMODE,
   // software register port
   input wire trui_pkg::trui_csr_req_t CSR_REQ,
   output logic [63:0] CSR_RDATA,
   // trap events
   input wire trui_pkg::trui_ctl_t CTL,
   input wire trui_pkg::trui_fault_t FAULT,
   input wire logic [63:0] USER_TRAP_PC,
   // interrupt sources
   input wire logic TIMER_PEND,
   input wire logic EXT_PEND,
   // state out
   output logic [63:0] PC,
   output logic [1:0] PRIV,
   output logic VIRT,
   output logic [31:0] TRAP_INSN,
   output logic USER_IRQ
);
   import trui_pkg::*;

   trui_state_t s_q, s_d;
   logic has_s_q;
   logic [63:0] s_mask;
   logic [31:0] xf;
   logic [63:0] uip_view;
   logic [8:0] udeleg;

   // ----------------------------------------
   // strap capture
   // ----------------------------------------
   assign has_s_q = s_q.smode_sync[1];

   // ----------------------------------------
   // trap instruction transform
   // ----------------------------------------
   always_comb begin
      xf = 32'h0;
      unique case (FAULT.kind)
         TRUI_FK_LOAD: begin
            xf = {17'h0, FAULT.insn[14:0]}; // RULE2
            xf[19:15] = FAULT.addr_offset; // RULE1
         end
         TRUI_FK_STORE: begin
            xf = {7'h0, FAULT.insn[24:20], 5'h0, FAULT.insn[14:12], 5'h0, FAULT.insn[6:0]}; // RULE2
            xf[19:15] = FAULT.addr_offset; // RULE1
         end
         TRUI_FK_ATOMIC, TRUI_FK_HYPLS: begin
            xf = FAULT.insn;
            xf[19:15] = FAULT.addr_offset; // RULE1
         end
         TRUI_FK_GUEST_IMPLICIT: begin
            if (FAULT.guest_addr_nonzero) begin // RULE4
               if (FAULT.guest_width64) begin // RULE5
                  xf = FAULT.ad_update ? `TRUI_PSEUDO_WR64 : `TRUI_PSEUDO_RD64; // RULE6
               end else begin
                  xf = FAULT.ad_update ? `TRUI_PSEUDO_WR32 : `TRUI_PSEUDO_RD32; // RULE6
               end
            end
         end
         default: xf = 32'h0;
      endcase
      // insn is the expanded form when compressed; bits 1:0 then 01
      if (FAULT.kind != TRUI_FK_GUEST_IMPLICIT && FAULT.kind != TRUI_FK_NONE && FAULT.insn[1:0] != 2'h3) begin
         xf[1:0] = 2'h1; // RULE3
      end else if (FAULT.kind != TRUI_FK_GUEST_IMPLICIT && FAULT.kind != TRUI_FK_NONE) begin
         xf[1:0] = 2'h3; // RULE3
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.smode_sync = {s_q.smode_sync[0], HAS_SMODE};
      s_mask = has_s_q ? s_q.medeleg : 64'h0;
      uip_view = 64'h0;
      uip_view[`TRUI_B_USOFT] = s_q.ip[`TRUI_B_USOFT];
      uip_view[`TRUI_B_UTIMER] = s_q.ip[`TRUI_B_UTIMER];
      uip_view[`TRUI_B_UEXT] = s_q.ip[`TRUI_B_UEXT];
      s_d.ip[`TRUI_B_UTIMER] = TIMER_PEND; // RULE18
      s_d.ip[`TRUI_B_UEXT] = EXT_PEND; // RULE19
      s_d.rdata = 64'h0;
      if (CSR_REQ.rd) begin
         unique case (CSR_REQ.addr)
            `TRUI_A_USTATUS: s_d.rdata = s_q.status & 64'h11; // RULE14
            `TRUI_A_MSTATUS: s_d.rdata = s_q.status; // RULE14
            `TRUI_A_UIP: s_d.rdata = uip_view; // RULE20
            `TRUI_A_MIP, `TRUI_A_SIP: s_d.rdata = s_q.ip; // RULE20
            `TRUI_A_UIE: s_d.rdata = s_q.ie & 64'h111; // RULE20
            `TRUI_A_MIE, `TRUI_A_SIE: s_d.rdata = s_q.ie;
            `TRUI_A_MEDELEG: s_d.rdata = s_q.medeleg;
            `TRUI_A_MIDELEG: s_d.rdata = s_q.mideleg;
            `TRUI_A_SEDELEG: s_d.rdata = s_q.sedeleg;
            `TRUI_A_SIDELEG: s_d.rdata = s_q.sideleg;
            `TRUI_A_MEPC: s_d.rdata = s_q.mepc;
            `TRUI_A_SEPC: s_d.rdata = s_q.sepc;
            `TRUI_A_UEPC: s_d.rdata = s_q.uepc;
            `TRUI_A_MTINST: s_d.rdata = {32'h0, s_q.tinst}; // RULE7
            `TRUI_A_MODE: s_d.rdata = {61'h0, s_q.virt, s_q.priv};
            default: s_d.rdata = 64'h0;
         endcase
      end
      if (CSR_REQ.wr) begin
         unique case (CSR_REQ.addr)
            `TRUI_A_USTATUS: begin
               s_d.status[`TRUI_B_UIE] = CSR_REQ.wdata[`TRUI_B_UIE]; // RULE14
               s_d.status[`TRUI_B_USER_PREV_INT_ENABLE] = CSR_REQ.wdata[`TRUI_B_USER_PREV_INT_ENABLE];
            end
            `TRUI_A_MSTATUS: s_d.status = CSR_REQ.wdata;
            `TRUI_A_UIP, `TRUI_A_MIP, `TRUI_A_SIP: begin
               s_d.ip[`TRUI_B_USOFT] = CSR_REQ.wdata[`TRUI_B_USOFT]; // RULE16 RULE17 RULE20
            end
            `TRUI_A_UIE: begin
               s_d.ie[`TRUI_B_USOFT] = CSR_REQ.wdata[`TRUI_B_USOFT]; // RULE20
               s_d.ie[`TRUI_B_UTIMER] = CSR_REQ.wdata[`TRUI_B_UTIMER];
               s_d.ie[`TRUI_B_UEXT] = CSR_REQ.wdata[`TRUI_B_UEXT];
            end
            `TRUI_A_MIE, `TRUI_A_SIE: s_d.ie = CSR_REQ.wdata;
            `TRUI_A_MEDELEG: s_d.medeleg = CSR_REQ.wdata;
            `TRUI_A_MIDELEG: s_d.mideleg = CSR_REQ.wdata;
            `TRUI_A_SEDELEG: s_d.sedeleg = CSR_REQ.wdata & s_mask; // RULE22
            `TRUI_A_SIDELEG: s_d.sideleg = CSR_REQ.wdata & (has_s_q ? s_q.mideleg : 64'h0); // RULE22
            `TRUI_A_MEPC: s_d.mepc = CSR_REQ.wdata;
            `TRUI_A_SEPC: s_d.sepc = CSR_REQ.wdata;
            `TRUI_A_UEPC: s_d.uepc = CSR_REQ.wdata;
            default: s_d.rdata = s_d.rdata;
         endcase
      end
      if (FAULT.valid) begin
         s_d.tinst = xf; // RULE7
      end
      if (CTL.machine_trap_return) begin
         s_d.priv = s_q.status[`TRUI_B_MPP +: 2]; // RULE8
         s_d.virt = s_q.status[`TRUI_B_MPV] && (s_q.status[`TRUI_B_MPP +: 2] != TRUI_PRV_M);
         s_d.status[`TRUI_B_MPP +: 2] = 2'h0; // RULE8
         s_d.status[`TRUI_B_MPV] = 1'b0;
         s_d.status[`TRUI_B_MIE] = s_q.status[`TRUI_B_MACHINE_PREV_INT_ENABLE];
         s_d.status[`TRUI_B_MACHINE_PREV_INT_ENABLE] = 1'b1;
         s_d.pc = s_q.mepc; // RULE9
      end else if (CTL.supervisor_trap_return && !s_q.virt) begin
         s_d.priv = {1'b0, s_q.status[`TRUI_B_SPP]}; // RULE10
         s_d.virt = s_q.hstatus_spv[0];
         s_d.hstatus_spv[0] = 1'b0;
         s_d.status[`TRUI_B_SPP] = 1'b0;
         s_d.status[`TRUI_B_SIE] = s_q.status[`TRUI_B_SUPERVISOR_PREV_INT_ENABLE];
         s_d.status[`TRUI_B_SUPERVISOR_PREV_INT_ENABLE] = 1'b1;
         s_d.pc = s_q.sepc;
      end else if (CTL.supervisor_trap_return) begin
         s_d.priv = {1'b0, s_q.vsstatus[`TRUI_B_SPP]}; // RULE11
         s_d.vsstatus[`TRUI_B_SPP] = 1'b0;
         s_d.vsstatus[`TRUI_B_SIE] = s_q.vsstatus[`TRUI_B_SUPERVISOR_PREV_INT_ENABLE];
         s_d.vsstatus[`TRUI_B_SUPERVISOR_PREV_INT_ENABLE] = 1'b1;
         s_d.pc = s_q.vsepc;
      end else if (CTL.user_trap_return) begin
         s_d.status[`TRUI_B_UIE] = s_q.status[`TRUI_B_USER_PREV_INT_ENABLE]; // RULE15
         s_d.status[`TRUI_B_USER_PREV_INT_ENABLE] = 1'b1;
         s_d.pc = s_q.uepc;
      end else if (CTL.user_trap_take) begin
         s_d.status[`TRUI_B_USER_PREV_INT_ENABLE] = s_q.status[`TRUI_B_UIE]; // RULE12
         s_d.status[`TRUI_B_UIE] = 1'b0;
         s_d.uepc = USER_TRAP_PC;
      end
      // delegation source: machine regs on M/U harts, supervisor regs otherwise
      s_d.uirq = s_q.status[`TRUI_B_UIE] && (s_q.priv == TRUI_PRV_U) && // RULE13 RULE23
         |(s_q.ip[8:0] & s_q.ie[8:0] & 9'h111 & // RULE16 RULE18 RULE19
         (has_s_q ? s_q.sideleg[8:0] : s_q.mideleg[8:0])); // RULE21 RULE22
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         s_q <= '0;
         s_q.priv <= 2'h3;
      end else begin
         s_q <= s_d;
      end
   end

   assign CSR_RDATA = s_q.rdata;
   assign PC = s_q.pc;
   assign PRIV = s_q.priv;
   assign VIRT = s_q.virt;
   assign TRAP_INSN = s_q.tinst;
   assign USER_IRQ = s_q.uirq;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_machine_trap_return;
      @(posedge REF_CLK) disable iff (RST)
      CTL.machine_trap_return |=> (PC == $past(s_q.mepc)) && s_q.status[`TRUI_B_MACHINE_PREV_INT_ENABLE] && !s_q.status[`TRUI_B_MPV];
   endproperty
   a_machine_trap_return: assert property (p_machine_trap_return) else $error("machine return wrong"); // RULE8 RULE9

   property p_machine_trap_return_mie;
      @(posedge REF_CLK) disable iff (RST)
      CTL.machine_trap_return |=> s_q.status[`TRUI_B_MIE] == $past(s_q.status[`TRUI_B_MACHINE_PREV_INT_ENABLE]);
   endproperty
   a_machine_trap_return_mie: assert property (p_machine_trap_return_mie) else $error("mie not popped"); // RULE8

   property p_supervisor_trap_return;
      @(posedge REF_CLK) disable iff (RST)
      (CTL.supervisor_trap_return && !CTL.machine_trap_return && !s_q.virt) |=> PC == $past(s_q.sepc);
   endproperty
   a_supervisor_trap_return: assert property (p_supervisor_trap_return) else $error("supervisor_trap_return pc wrong"); // RULE10

   property p_vsret;
      @(posedge REF_CLK) disable iff (RST)
      (CTL.supervisor_trap_return && !CTL.machine_trap_return && s_q.virt) |=> s_q.vsstatus[`TRUI_B_SUPERVISOR_PREV_INT_ENABLE];
   endproperty
   a_vsret: assert property (p_vsret) else $error("guest return wrong"); // RULE11

   property p_utake;
      @(posedge REF_CLK) disable iff (RST)
      (CTL.user_trap_take && !(|CTL[3:1])) |=> !s_q.status[`TRUI_B_UIE];
   endproperty
   a_utake: assert property (p_utake) else $error("uie not cleared"); // RULE12

   property p_uie_mask;
      @(posedge REF_CLK) disable iff (RST)
      !s_q.status[`TRUI_B_UIE] |=> !USER_IRQ;
   endproperty
   a_uie_mask: assert property (p_uie_mask) else $error("irq with uie clear"); // RULE13

   property p_user_trap_return;
      @(posedge REF_CLK) disable iff (RST)
      (CTL.user_trap_return && !(|CTL[3:2])) |=> PC == $past(s_q.uepc) && s_q.status[`TRUI_B_USER_PREV_INT_ENABLE];
   endproperty
   a_user_trap_return: assert property (p_user_trap_return) else $error("user return wrong"); // RULE15

   property p_pseudo;
      @(posedge REF_CLK) disable iff (RST)
      (FAULT.valid && FAULT.kind == TRUI_FK_GUEST_IMPLICIT && FAULT.guest_addr_nonzero) |=> TRAP_INSN != 32'h0;
   endproperty
   a_pseudo: assert property (p_pseudo) else $error("pseudo value zero"); // RULE4

   property p_sedeleg;
      @(posedge REF_CLK) disable iff (RST)
      1'b1 |-> (s_q.sedeleg & ~(has_s_q ? s_q.medeleg : 64'h0)) == 64'h0 || $past(CSR_REQ.addr) == `TRUI_A_MEDELEG;
   endproperty
   a_sedeleg: assert property (p_sedeleg) else $error("sedeleg bit not delegated"); // RULE22

   // ----------------------------------------
   // trap return, trap instruction, register view and interrupt checks
   // ----------------------------------------
   assign udeleg = has_s_q ? s_q.sideleg[8:0] : s_q.mideleg[8:0];

   sequence s_machine_trap_return_req;
      CTL.machine_trap_return;
   endsequence

   sequence s_supervisor_trap_return_hs;
      CTL.supervisor_trap_return && !CTL.machine_trap_return && !s_q.virt;
   endsequence

   sequence s_supervisor_trap_return_vs;
      CTL.supervisor_trap_return && !CTL.machine_trap_return && s_q.virt;
   endsequence

   sequence s_user_trap_return_req;
      CTL.user_trap_return && !(|CTL[3:2]);
   endsequence

   sequence s_utake_req;
      CTL.user_trap_take && !(|CTL[3:1]);
   endsequence

   sequence s_guest_fault;
      FAULT.valid && FAULT.kind == TRUI_FK_GUEST_IMPLICIT && FAULT.guest_addr_nonzero;
   endsequence

   sequence s_xf_fault;
      FAULT.valid && FAULT.kind inside {TRUI_FK_LOAD, TRUI_FK_STORE, TRUI_FK_ATOMIC, TRUI_FK_HYPLS};
   endsequence

   sequence s_uirq_open;
      s_q.status[`TRUI_B_UIE] && s_q.priv == TRUI_PRV_U;
   endsequence

   property p_machine_trap_return_priv;
      @(posedge REF_CLK) disable iff (RST)
      s_machine_trap_return_req |=> PRIV == $past(s_q.status[`TRUI_B_MPP +: 2]) && s_q.status[`TRUI_B_MPP +: 2] == 2'h0;
   endproperty
   a_machine_trap_return_priv: assert property (p_machine_trap_return_priv) else $error("machine return mode wrong"); // RULE8

   property p_supervisor_trap_return_mode;
      @(posedge REF_CLK) disable iff (RST)
      s_supervisor_trap_return_hs |=> PRIV == {1'h0, $past(s_q.status[`TRUI_B_SPP])} && !s_q.status[`TRUI_B_SPP]
         && VIRT == $past(s_q.hstatus_spv[0]);
   endproperty
   a_supervisor_trap_return_mode: assert property (p_supervisor_trap_return_mode) else $error("supervisor_trap_return mode wrong"); // RULE10

   property p_vsret_pc;
      @(posedge REF_CLK) disable iff (RST)
      s_supervisor_trap_return_vs |=> PC == $past(s_q.vsepc) && VIRT && !s_q.vsstatus[`TRUI_B_SPP];
   endproperty
   a_vsret_pc: assert property (p_vsret_pc) else $error("guest return pc wrong"); // RULE11

   property p_user_trap_return_uie;
      @(posedge REF_CLK) disable iff (RST)
      s_user_trap_return_req |=> s_q.status[`TRUI_B_UIE] == $past(s_q.status[`TRUI_B_USER_PREV_INT_ENABLE]);
   endproperty
   a_user_trap_return_uie: assert property (p_user_trap_return_uie) else $error("uie not popped"); // RULE15

   property p_utake_user_prev_int_enable;
      @(posedge REF_CLK) disable iff (RST)
      s_utake_req |=> s_q.status[`TRUI_B_USER_PREV_INT_ENABLE] == $past(s_q.status[`TRUI_B_UIE]) && s_q.uepc == $past(USER_TRAP_PC);
   endproperty
   a_utake_user_prev_int_enable: assert property (p_utake_user_prev_int_enable) else $error("user_prev_int_enable not pushed"); // RULE12

   property p_pseudo_rd;
      @(posedge REF_CLK) disable iff (RST)
      s_guest_fault ##0 !FAULT.ad_update |=>
         TRAP_INSN == ($past(FAULT.guest_width64) ? `TRUI_PSEUDO_RD64 : `TRUI_PSEUDO_RD32);
   endproperty
   a_pseudo_rd: assert property (p_pseudo_rd) else $error("read pseudo value wrong"); // RULE5

   property p_pseudo_wr;
      @(posedge REF_CLK) disable iff (RST)
      s_guest_fault ##0 FAULT.ad_update |=>
         TRAP_INSN == ($past(FAULT.guest_width64) ? `TRUI_PSEUDO_WR64 : `TRUI_PSEUDO_WR32);
   endproperty
   a_pseudo_wr: assert property (p_pseudo_wr) else $error("write pseudo value wrong"); // RULE6

   property p_ld_xf;
      @(posedge REF_CLK) disable iff (RST)
      FAULT.valid && FAULT.kind == TRUI_FK_LOAD |=> TRAP_INSN[31:15] == {12'h0, $past(FAULT.addr_offset)};
   endproperty
   a_ld_xf: assert property (p_ld_xf) else $error("load transform wrong"); // RULE1 RULE2

   property p_cmp_bits;
      @(posedge REF_CLK) disable iff (RST)
      s_xf_fault ##0 (FAULT.insn[1:0] != 2'h3) |=> TRAP_INSN[1:0] == 2'h1;
   endproperty
   a_cmp_bits: assert property (p_cmp_bits) else $error("compressed low bits wrong"); // RULE3

   property p_unc_bits;
      @(posedge REF_CLK) disable iff (RST)
      s_xf_fault ##0 (FAULT.insn[1:0] == 2'h3) |=> TRAP_INSN[1:0] == 2'h3;
   endproperty
   a_unc_bits: assert property (p_unc_bits) else $error("full size low bits wrong"); // RULE3

   property p_ustatus_view;
      @(posedge REF_CLK) disable iff (RST)
      CSR_REQ.rd && CSR_REQ.addr == `TRUI_A_USTATUS |=> CSR_RDATA[`TRUI_B_USER_PREV_INT_ENABLE] == $past(s_q.status[`TRUI_B_USER_PREV_INT_ENABLE]);
   endproperty
   a_ustatus_view: assert property (p_ustatus_view) else $error("user status view wrong"); // RULE14

   property p_soft_wr;
      @(posedge REF_CLK) disable iff (RST)
      CSR_REQ.wr && CSR_REQ.addr == `TRUI_A_UIP |=> s_q.ip[`TRUI_B_USOFT] == $past(CSR_REQ.wdata[`TRUI_B_USOFT]);
   endproperty
   a_soft_wr: assert property (p_soft_wr) else $error("soft pending not written"); // RULE16

   property p_uip_ro;
      @(posedge REF_CLK) disable iff (RST)
      CSR_REQ.wr && CSR_REQ.addr == `TRUI_A_UIP |=> s_q.ip[`TRUI_B_UTIMER] == $past(TIMER_PEND);
   endproperty
   a_uip_ro: assert property (p_uip_ro) else $error("timer pending written"); // RULE17

   property p_soft_irq;
      @(posedge REF_CLK) disable iff (RST)
      s_uirq_open ##0 (s_q.ip[`TRUI_B_USOFT] && s_q.ie[`TRUI_B_USOFT] && udeleg[`TRUI_B_USOFT]) |=> USER_IRQ;
   endproperty
   a_soft_irq: assert property (p_soft_irq) else $error("soft irq not raised"); // RULE16

   property p_timer_irq;
      @(posedge REF_CLK) disable iff (RST)
      s_uirq_open ##0 (s_q.ip[`TRUI_B_UTIMER] && s_q.ie[`TRUI_B_UTIMER] && udeleg[`TRUI_B_UTIMER]) |=> USER_IRQ;
   endproperty
   a_timer_irq: assert property (p_timer_irq) else $error("timer irq not raised"); // RULE18

   property p_ext_irq;
      @(posedge REF_CLK) disable iff (RST)
      s_uirq_open ##0 (s_q.ip[`TRUI_B_UEXT] && s_q.ie[`TRUI_B_UEXT] && udeleg[`TRUI_B_UEXT]) |=> USER_IRQ;
   endproperty
   a_ext_irq: assert property (p_ext_irq) else $error("external irq not raised"); // RULE19

   property p_irq_mask;
      @(posedge REF_CLK) disable iff (RST)
      (s_q.ip[8:0] & s_q.ie[8:0] & 9'h111) == 9'h0 |=> !USER_IRQ;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised"); // RULE16 RULE18 RULE19
endmodule : trui_unit
`default_nettype wire

//--- tb/trui_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "trui_defines.svh"
module trui_bench;
   import trui_pkg::*;
   typedef struct packed {logic [2:0] what; logic [63:0] val; int due;} trui_note_t;
   logic ref_clk, rst, has_smode, timer_pend, ext_pend, virt, user_irq;
   trui_csr_req_t csr_req;
   trui_ctl_t ctl;
   trui_fault_t fault, f;
   logic [63:0] csr_rdata, user_trap_pc, pc;
   logic [1:0] priv;
   logic [31:0] trap_insn, rnd;
   trui_note_t q[$];
   trui_note_t nt;
   int cyc, err_total, n_checks;
   trui_unit dut (
      .REF_CLK(ref_clk),
      .RST(rst),
      .HAS_SMODE(has_smode),
      .CSR_REQ(csr_req),
      .CSR_RDATA(csr_rdata),
      .CTL(ctl),
      .FAULT(fault),
      .USER_TRAP_PC(user_trap_pc),
      .TIMER_PEND(timer_pend),
      .EXT_PEND(ext_pend),
      .PC(pc),
      .PRIV(priv),
      .VIRT(virt),
      .TRAP_INSN(trap_insn),
      .USER_IRQ(user_irq)
   );
   always #50 ref_clk = ~ref_clk;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [63:0] bv(input int n);
      return 64'h1 << n;
   endfunction : bv
   // expected trap instruction value
   function automatic logic [31:0] xf(input trui_fault_t g);
      logic [31:0] e;
      case (g.kind)
         TRUI_FK_LOAD: e = {12'h0, g.addr_offset, g.insn[14:0]};
         TRUI_FK_STORE: e = {7'h0, g.insn[24:20], g.addr_offset, g.insn[14:12], 5'h0, g.insn[6:0]};
         TRUI_FK_GUEST_IMPLICIT: begin
            if (g.guest_width64) return g.ad_update ? `TRUI_PSEUDO_WR64 : `TRUI_PSEUDO_RD64;
            return g.ad_update ? `TRUI_PSEUDO_WR32 : `TRUI_PSEUDO_RD32;
         end
         default: e = {g.insn[31:20], g.addr_offset, g.insn[14:0]};
      endcase
      e[1:0] = (g.insn[1:0] == 2'h3) ? 2'h3 : 2'h1;
      return e;
   endfunction : xf
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic expect_at(input logic [2:0] w, input logic [63:0] v, input int off);
      q.push_back('{w, v, cyc + off});
   endtask : expect_at
   task automatic wr(input logic [11:0] a, input logic [63:0] d);
      csr_req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      csr_req <= '0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [63:0] exp);
      expect_at(3'h0, exp, 2);
      csr_req <= '{a, 64'h0, 1'b0, 1'b1};
      @(posedge ref_clk);
      csr_req <= '0;
      @(posedge ref_clk);
   endtask : rd
   task automatic pulse(input trui_ctl_t c);
      ctl <= c;
      @(posedge ref_clk);
      ctl <= '0;
      @(posedge ref_clk);
   endtask : pulse
   task automatic irq(input logic v);
      repeat (3) @(posedge ref_clk);
      expect_at(3'h4, {63'h0, v}, 1);
      @(posedge ref_clk);
   endtask : irq
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   // ----------------------------------------
   // output watcher
   // ----------------------------------------
   initial forever begin
      @(posedge ref_clk);
      #1;
      cyc++;
      while (q.size() > 0 && q[0].due <= cyc) begin
         nt = q.pop_front();
         case (nt.what)
            3'h0: check(csr_rdata, nt.val);
            3'h1: check(pc, nt.val);
            3'h2: check({62'h0, priv}, nt.val);
            3'h3: check({32'h0, trap_insn}, nt.val);
            3'h4: check({63'h0, user_irq}, nt.val);
            default: check({63'h0, virt}, nt.val);
         endcase
      end
      if (cyc > 3000) begin
         err_total++;
         end_sim();
      end
   end
   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      has_smode = 1'b0;
      csr_req = '0;
      ctl = '0;
      fault = '0;
      user_trap_pc = 64'h0;
      timer_pend = 1'b0;
      ext_pend = 1'b0;
      rnd = 32'h3a;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      expect_at(3'h2, 64'h3, 1);
      rd(`TRUI_A_MSTATUS, 64'h0);
      for (int i = 0; i < 20; i++) begin
         rnd = lfsr(rnd);
         f = '{1'b1, trui_fault_kind_t'(i % 5 + 1), rnd, rnd[26:22], 1'b1, rnd[7], rnd[9]};
         expect_at(3'h3, {32'h0, xf(f)}, 2);
         fault <= f;
         @(posedge ref_clk);
         fault <= '0;
         @(posedge ref_clk);
      end
      $display("test fault values done");
      wr(`TRUI_A_MSTATUS, bv(`TRUI_B_MPP) | bv(`TRUI_B_MACHINE_PREV_INT_ENABLE));
      wr(`TRUI_A_MEPC, 64'h1230);
      expect_at(3'h1, 64'h1230, 2);
      expect_at(3'h2, 64'h1, 2);
      pulse('{1'b1, 1'b0, 1'b0, 1'b0});
      rd(`TRUI_A_MSTATUS, bv(`TRUI_B_MIE) | bv(`TRUI_B_MACHINE_PREV_INT_ENABLE));
      wr(`TRUI_A_MSTATUS, bv(`TRUI_B_SIE));
      wr(`TRUI_A_SEPC, 64'h4560);
      expect_at(3'h1, 64'h4560, 2);
      expect_at(3'h2, 64'h0, 2);
      expect_at(3'h5, 64'h0, 2);
      pulse('{1'b0, 1'b1, 1'b0, 1'b0});
      rd(`TRUI_A_MSTATUS, bv(`TRUI_B_SUPERVISOR_PREV_INT_ENABLE));
      wr(`TRUI_A_MSTATUS, bv(`TRUI_B_MPV) | bv(`TRUI_B_MPP));
      expect_at(3'h5, 64'h1, 2);
      pulse('{1'b1, 1'b0, 1'b0, 1'b0});
      expect_at(3'h1, 64'h0, 2);
      expect_at(3'h2, 64'h0, 2);
      expect_at(3'h5, 64'h1, 2);
      pulse('{1'b0, 1'b1, 1'b0, 1'b0});
      $display("test trap returns done");
      wr(`TRUI_A_USTATUS, bv(`TRUI_B_UIE));
      user_trap_pc <= 64'h7890;
      pulse('{1'b0, 1'b0, 1'b0, 1'b1});
      rd(`TRUI_A_USTATUS, bv(`TRUI_B_USER_PREV_INT_ENABLE));
      rd(`TRUI_A_MSTATUS, bv(`TRUI_B_MACHINE_PREV_INT_ENABLE) | bv(`TRUI_B_USER_PREV_INT_ENABLE));
      expect_at(3'h1, 64'h7890, 2);
      pulse('{1'b0, 1'b0, 1'b1, 1'b0});
      rd(`TRUI_A_USTATUS, bv(`TRUI_B_UIE) | bv(`TRUI_B_USER_PREV_INT_ENABLE));
      $display("test user trap done");
      wr(`TRUI_A_MIDELEG, 64'h111);
      wr(`TRUI_A_UIE, bv(`TRUI_B_USOFT));
      wr(`TRUI_A_UIP, bv(`TRUI_B_USOFT));
      irq(1'b1);
      wr(`TRUI_A_UIP, 64'h0);
      irq(1'b0);
      wr(`TRUI_A_UIP, bv(`TRUI_B_USOFT));
      wr(`TRUI_A_UIE, 64'h0);
      irq(1'b0);
      wr(`TRUI_A_UIP, 64'h0);
      timer_pend <= 1'b1;
      wr(`TRUI_A_UIE, bv(`TRUI_B_UTIMER));
      irq(1'b1);
      wr(`TRUI_A_USTATUS, 64'h0);
      irq(1'b0);
      timer_pend <= 1'b0;
      ext_pend <= 1'b1;
      wr(`TRUI_A_USTATUS, bv(`TRUI_B_UIE));
      wr(`TRUI_A_UIE, bv(`TRUI_B_UEXT));
      irq(1'b1);
      wr(`TRUI_A_MIDELEG, 64'h0);
      irq(1'b0);
      wr(`TRUI_A_UIP, ~64'h0);
      rd(`TRUI_A_UIP, bv(`TRUI_B_USOFT) | bv(`TRUI_B_UEXT));
      rd(`TRUI_A_MIP, bv(`TRUI_B_USOFT) | bv(`TRUI_B_UEXT));
      $display("test user interrupts done");
      has_smode <= 1'b1;
      wr(`TRUI_A_MEDELEG, 64'hf0f);
      wr(`TRUI_A_SEDELEG, ~64'h0);
      rd(`TRUI_A_SEDELEG, 64'hf0f);
      wr(`TRUI_A_SIDELEG, ~64'h0);
      rd(`TRUI_A_SIDELEG, 64'h0);
      rd(`TRUI_A_SIP, bv(`TRUI_B_USOFT) | bv(`TRUI_B_UEXT));
      rd(12'h7ff, 64'h0);
      repeat (3) @(posedge ref_clk);
      $display("test delegation done");
      end_sim();
   end
endmodule : trui_bench
`default_nettype wire
